// file: core/pcd_pkg.sv
// Package: register map, field layout, reset values and carrier types for pin change detect
//------------------------------------------------------------
// Notes on behaviour
// RULE1 - Port B pins 7..4 rising enable arms rising detection; clear disables it.
// RULE2 - Port B pins 7..4 falling enable arms falling detection; clear disables it.
// RULE3 - Port B flag sets on enabled rising or enabled falling edge of its pin.
// RULE4 - Port B bits 3..0 of enables and flags read zero, writes ignored.
// RULE5 - Each port C pin 7..0 has a rising enable arming rising detection.
// RULE6 - Each port C pin 7..0 has a falling enable arming falling detection.
// RULE7 - Port C flag sets on enabled rising or enabled falling edge of its pin.
// RULE8 - Any enabled edge setting a pin flag also sets the summary flag.
// RULE9 - Pin flags set by hardware stay set until software writes zero.
// RULE10 - All enables and flags reset to zero on every reset.
// RULE11 - Hardware sets flags independently of software writes to the register.
// RULE12 - Master enable cleared: detection and flags continue, no interrupt raised; code still drives irqOut from irqStat and irqMask.
// RULE13 - Summary flag is the OR of all pin change flags.
// RULE14 - Edge during a clearing write leaves the flag set.
// RULE15 - With master enable, a change raises wake; flags updated before wake.
// RULE16 - Pins synchronised to clock; current versus previous sample gives edge pulses; code gives an edge only once stages two and three agree.
// RULE17 - Small variant: port B and port C pins 7,6 bits read zero, never set.
//------------------------------------------------------------
package pcd_pkg;
	localparam int DATA_W = 32;
	localparam int PORT_W = 8;
	localparam logic [11:0] OFF_B_RISE = 12'h000;
	localparam logic [11:0] OFF_B_FALL = 12'h004;
	localparam logic [11:0] OFF_B_FLAG = 12'h008;
	localparam logic [11:0] OFF_C_RISE = 12'h00C;
	localparam logic [11:0] OFF_C_FALL = 12'h010;
	localparam logic [11:0] OFF_C_FLAG = 12'h014;
	localparam logic [11:0] OFF_CTRL = 12'h018;
	localparam logic [11:0] OFF_IRQ_STAT = 12'h01C;
	localparam logic [11:0] OFF_IRQ_MASK = 12'h020;
	localparam int CTRL_MIE_BIT = 0;
	localparam int CTRL_SUM_BIT = 1;
	localparam logic [7:0] B_IMPL_MASK = 8'hF0;
	localparam logic [7:0] C_IMPL_MASK = 8'hFF;
	localparam logic [7:0] SMALL_C_MASK = 8'h3F;
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam int IRQ_B_BIT = 0;
	localparam int IRQ_C_BIT = 1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef struct packed {
		logic [7:0] riseEn;
		logic [7:0] fallEn;
		logic [7:0] flags;
	} pcd_port_t;
endpackage

// file: core/pcd_sync_edge.sv
// Module: three-stage pin synchroniser with rise and fall pulse outputs
`timescale 1ns/1ps
module pcd_sync_edge
	import pcd_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Pins and pulses
	input wire logic [PORT_W-1:0] pinIn,
	output logic [PORT_W-1:0] risePulse,
	output logic [PORT_W-1:0] fallPulse
);
	typedef struct packed {
		logic [PORT_W-1:0] s1;
		logic [PORT_W-1:0] s2;
		logic [PORT_W-1:0] s3;
		logic [PORT_W-1:0] lvl;
		logic [1:0] fill;
	} pcd_sync_t;
	pcd_sync_t state_r, state_nxt;
	logic [PORT_W-1:0] agree;
	logic primed;

	// A pin level counts only once stages two and three agree
	assign agree = ~(state_r.s2 ^ state_r.s3);
	assign primed = (state_r.fill == 2'h3);

	// Shift chain; s1 only feeds s2 to keep metastability contained
	always_comb begin
		state_nxt = state_r;
		state_nxt.s1 = pinIn;
		state_nxt.s2 = state_r.s1;
		state_nxt.s3 = state_r.s2;
		// While the chain fills, the level loads from stage two, so a pin that is
		// already high at reset release gives no false edge
		if (!primed) begin
			state_nxt.fill = state_r.fill + 2'h1;
			state_nxt.lvl = state_r.s2;
		end else begin
			state_nxt.lvl = (agree & state_r.s3) | (~agree & state_r.lvl);
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_r <= '0;
		end else begin
			state_r <= state_nxt;
		end
	end

	// An agreed level that differs from the held one is one edge, one cycle long [RULE16]
	assign risePulse = primed ? (agree & state_r.s3 & ~state_r.lvl) : '0; // [RULE16]
	assign fallPulse = primed ? (agree & ~state_r.s3 & state_r.lvl) : '0; // [RULE16]

	a_rise_one_cycle: assert property (@(posedge core_clk) disable iff (rst) // [RULE16]
		|risePulse |=> ((risePulse & $past(risePulse)) == '0))
		else $error("rise pulse lasted more than one cycle");
endmodule

// file: core/pcd_port.sv
// Module: one port of enables and hardware-set flags
`timescale 1ns/1ps
module pcd_port
	import pcd_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Bit mask of pins that exist
	input wire logic [PORT_W-1:0] implMask,
	// Software writes
	input wire logic wrRise,
	input wire logic wrFall,
	input wire logic wrFlag,
	input wire logic [PORT_W-1:0] wrData,
	// Edge pulses
	input wire logic [PORT_W-1:0] risePulse,
	input wire logic [PORT_W-1:0] fallPulse,
	// State
	output pcd_port_t portState,
	output logic setAny
);
	pcd_port_t state_r, state_nxt;
	logic [PORT_W-1:0] hit;

	// Enabled edges on existing pins only [RULE3] [RULE7] [RULE17]
	assign hit = implMask & ((risePulse & state_r.riseEn) | (fallPulse & state_r.fallEn));
	assign setAny = |hit;

	always_comb begin
		state_nxt = state_r;
		if (wrRise) begin
			state_nxt.riseEn = wrData & implMask; // [RULE1] [RULE5] [RULE4]
		end
		if (wrFall) begin
			state_nxt.fallEn = wrData & implMask; // [RULE2] [RULE6] [RULE4]
		end
		if (wrFlag) begin
			state_nxt.flags = wrData & implMask; // [RULE9]
		end
		// Set wins over a same-cycle clearing write [RULE11] [RULE14]
		state_nxt.flags = (state_nxt.flags | hit) & implMask;
		state_nxt.riseEn = state_nxt.riseEn & implMask;
		state_nxt.fallEn = state_nxt.fallEn & implMask;
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_r <= '0; // [RULE10]
		end else begin
			state_r <= state_nxt;
		end
	end

	assign portState = state_r;

	a_flag_set_wins: assert property (@(posedge core_clk) disable iff (rst) // [RULE14]
		|hit |=> ((state_r.flags & $past(hit)) == $past(hit)))
		else $error("edge lost against flag write");
	a_flag_sticky: assert property (@(posedge core_clk) disable iff (rst) // [RULE9]
		!wrFlag |=> ((state_r.flags & $past(state_r.flags)) == $past(state_r.flags)))
		else $error("flag dropped without write");
	a_unimpl_zero: assert property (@(posedge core_clk) disable iff (rst) // [RULE4]
		((state_r.flags | state_r.riseEn | state_r.fallEn) & ~implMask) == '0)
		else $error("unimplemented bit set");
	a_disabled_no_set: assert property (@(posedge core_clk) disable iff (rst) // [RULE1]
		(!wrFlag && (state_r.riseEn | state_r.fallEn) == '0)
		|=> state_r.flags == $past(state_r.flags))
		else $error("flag set with edges disabled");
endmodule

// file: core/pcd_top.sv
// Module: pin change detect for ports B and C with AXI4-Lite register access
`timescale 1ns/1ps
module pcd_top
	import pcd_pkg::*;
(
	// Clock and reset
	input wire logic core_clk,
	input wire logic rst,
	// Variant strap: high selects the small variant without port B and C pins 7,6
	input wire logic smallVariant,
	// Pins
	input wire logic [PORT_W-1:0] port_b_pin,
	input wire logic [PORT_W-1:0] port_c_pin,
	// AXI4-Lite write address
	input wire logic [11:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [DATA_W-1:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [11:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [DATA_W-1:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Interrupt and wake
	output logic changeIrq,
	output logic wakeReq,
	output logic irqOut
);
	//------------------------------------------------------------
	// State
	//------------------------------------------------------------
	typedef struct packed {
		logic haveAw;
		logic haveW;
		logic [11:0] awAddr;
		logic [7:0] wData;
		logic wLane0;
		logic bValid;
		logic [1:0] bResp;
		logic rValid;
		logic [DATA_W-1:0] rData;
		logic [1:0] rResp;
		logic mie;
		logic [1:0] irqStat;
		logic [1:0] irqMask;
		logic strapSmall;
		logic strapDone;
	} pcd_top_t;
	pcd_top_t state_r, state_nxt;

	logic [PORT_W-1:0] bRise, bFall, cRise, cFall;
	logic [PORT_W-1:0] bMask, cMask;
	logic bSet, cSet;
	pcd_port_t bState, cState;
	logic wrGo;
	logic wrB0, wrB1, wrB2, wrC0, wrC1, wrC2;
	logic summary;

	// True when the address names a mapped register
	function automatic logic addrMapped(input logic [11:0] a);
		return (a == OFF_B_RISE) || (a == OFF_B_FALL) || (a == OFF_B_FLAG) ||
			(a == OFF_C_RISE) || (a == OFF_C_FALL) || (a == OFF_C_FLAG) ||
			(a == OFF_CTRL) || (a == OFF_IRQ_STAT) || (a == OFF_IRQ_MASK);
	endfunction

	//------------------------------------------------------------
	// Pin synchronisers and ports
	//------------------------------------------------------------
	pcd_sync_edge u_sync_b (
		.core_clk(core_clk),
		.rst(rst),
		.pinIn(port_b_pin),
		.risePulse(bRise),
		.fallPulse(bFall)
	);
	pcd_sync_edge u_sync_c (
		.core_clk(core_clk),
		.rst(rst),
		.pinIn(port_c_pin),
		.risePulse(cRise),
		.fallPulse(cFall)
	);

	// Small variant drops port B entirely and port C pins 7,6 [RULE17]
	assign bMask = state_r.strapSmall ? 8'h00 : B_IMPL_MASK; // [RULE17] [RULE4]
	assign cMask = state_r.strapSmall ? SMALL_C_MASK : C_IMPL_MASK; // [RULE17]

	// A write lands once address and data are both held and the lane 0 strobe is on
	assign wrGo = state_r.haveAw && state_r.haveW && !state_r.bValid;
	assign wrB0 = wrGo && state_r.wLane0 && state_r.awAddr == OFF_B_RISE;
	assign wrB1 = wrGo && state_r.wLane0 && state_r.awAddr == OFF_B_FALL;
	assign wrB2 = wrGo && state_r.wLane0 && state_r.awAddr == OFF_B_FLAG;
	assign wrC0 = wrGo && state_r.wLane0 && state_r.awAddr == OFF_C_RISE;
	assign wrC1 = wrGo && state_r.wLane0 && state_r.awAddr == OFF_C_FALL;
	assign wrC2 = wrGo && state_r.wLane0 && state_r.awAddr == OFF_C_FLAG;

	pcd_port u_port_b (
		.core_clk(core_clk),
		.rst(rst),
		.implMask(bMask),
		.wrRise(wrB0),
		.wrFall(wrB1),
		.wrFlag(wrB2),
		.wrData(state_r.wData),
		.risePulse(bRise),
		.fallPulse(bFall),
		.portState(bState),
		.setAny(bSet)
	);
	pcd_port u_port_c (
		.core_clk(core_clk),
		.rst(rst),
		.implMask(cMask),
		.wrRise(wrC0),
		.wrFall(wrC1),
		.wrFlag(wrC2),
		.wrData(state_r.wData),
		.risePulse(cRise),
		.fallPulse(cFall),
		.portState(cState),
		.setAny(cSet)
	);

	// Summary is the OR of every pin flag, so it follows sets and clears [RULE8] [RULE13]
	assign summary = (|bState.flags) | (|cState.flags); // [RULE13]

	//------------------------------------------------------------
	// Bus slave and control
	//------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		// Strap caught once after reset release
		if (!state_r.strapDone) begin
			state_nxt.strapSmall = smallVariant;
			state_nxt.strapDone = 1'b1;
		end
		// Write address and data accepted in either order
		if (s_axi_awvalid && !state_r.haveAw) begin
			state_nxt.haveAw = 1'b1;
			state_nxt.awAddr = {s_axi_awaddr[11:2], 2'b00};
		end
		if (s_axi_wvalid && !state_r.haveW) begin
			state_nxt.haveW = 1'b1;
			state_nxt.wData = s_axi_wdata[7:0];
			state_nxt.wLane0 = s_axi_wstrb[0];
		end
		// Event sticky bits; a same-cycle write-one clear loses to the set
		if (wrGo) begin
			state_nxt.haveAw = 1'b0;
			state_nxt.haveW = 1'b0;
			state_nxt.bValid = 1'b1;
			state_nxt.bResp = addrMapped(state_r.awAddr) ? RESP_OKAY : RESP_SLVERR;
			if (state_r.wLane0 && state_r.awAddr == OFF_CTRL) begin
				state_nxt.mie = state_r.wData[CTRL_MIE_BIT];
			end
			if (state_r.wLane0 && state_r.awAddr == OFF_IRQ_STAT) begin
				state_nxt.irqStat = state_r.irqStat & ~state_r.wData[1:0];
			end
			if (state_r.wLane0 && state_r.awAddr == OFF_IRQ_MASK) begin
				state_nxt.irqMask = state_r.wData[1:0];
			end
		end
		if (bSet) begin
			state_nxt.irqStat[IRQ_B_BIT] = 1'b1;
		end
		if (cSet) begin
			state_nxt.irqStat[IRQ_C_BIT] = 1'b1;
		end
		if (state_r.bValid && s_axi_bready) begin
			state_nxt.bValid = 1'b0;
		end
		// Read: one cycle from address to data
		if (s_axi_arvalid && !state_r.rValid) begin
			state_nxt.rValid = 1'b1;
			state_nxt.rResp = addrMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			unique case ({s_axi_araddr[11:2], 2'b00})
				OFF_B_RISE: state_nxt.rData = {24'h000000, bState.riseEn};
				OFF_B_FALL: state_nxt.rData = {24'h000000, bState.fallEn};
				OFF_B_FLAG: state_nxt.rData = {24'h000000, bState.flags};
				OFF_C_RISE: state_nxt.rData = {24'h000000, cState.riseEn};
				OFF_C_FALL: state_nxt.rData = {24'h000000, cState.fallEn};
				OFF_C_FLAG: state_nxt.rData = {24'h000000, cState.flags};
				OFF_CTRL: state_nxt.rData = {30'h0, summary, state_r.mie};
				OFF_IRQ_STAT: state_nxt.rData = {30'h0, state_r.irqStat};
				OFF_IRQ_MASK: state_nxt.rData = {30'h0, state_r.irqMask};
				default: state_nxt.rData = 32'h00000000;
			endcase
		end else if (state_r.rValid && s_axi_rready) begin
			state_nxt.rValid = 1'b0;
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_r <= '0; // [RULE10]
		end else begin
			state_r <= state_nxt;
		end
	end

	//------------------------------------------------------------
	// Bus outputs
	//------------------------------------------------------------
	assign s_axi_awready = !state_r.haveAw;
	assign s_axi_wready = !state_r.haveW;
	assign s_axi_bvalid = state_r.bValid;
	assign s_axi_bresp = state_r.bResp;
	assign s_axi_arready = !state_r.rValid;
	assign s_axi_rvalid = state_r.rValid;
	assign s_axi_rdata = state_r.rData;
	assign s_axi_rresp = state_r.rResp;

	// Master enable gates only the request, never detection [RULE12] [RULE15]
	assign changeIrq = state_r.mie & summary; // [RULE12]
	assign wakeReq = state_r.mie & summary; // [RULE15]
	assign irqOut = |(state_r.irqStat & state_r.irqMask);

	//------------------------------------------------------------
	// Checks
	//------------------------------------------------------------
	// Summary and master enable
	a_summary_or: assert property (@(posedge core_clk) disable iff (rst) // [RULE8]
		(bSet || cSet) |=> summary)
		else $error("summary not set after edge");
	a_mie_gates: assert property (@(posedge core_clk) disable iff (rst) // [RULE12]
		!state_r.mie |-> !changeIrq)
		else $error("interrupt raised with master enable off");
	a_irq_follows: assert property (@(posedge core_clk) disable iff (rst) // [RULE15]
		(state_r.mie && summary) |-> (changeIrq && wakeReq))
		else $error("wake or interrupt missing");
	a_summary_clear: assert property (@(posedge core_clk) disable iff (rst) // [RULE13]
		(bState.flags == '0 && cState.flags == '0) |-> !summary)
		else $error("summary set without flags");

	// Enabled edges land on their own flag bit, not merely on some flag
	a_b_edge_sets: assert property (@(posedge core_clk) disable iff (rst) // [RULE3]
		(|(bRise & bState.riseEn & bMask))
		|=> ((bState.flags & $past(bRise & bState.riseEn & bMask))
			== $past(bRise & bState.riseEn & bMask)))
		else $error("port B rising edge lost");
	a_b_fall_sets: assert property (@(posedge core_clk) disable iff (rst) // [RULE3]
		(|(bFall & bState.fallEn & bMask))
		|=> ((bState.flags & $past(bFall & bState.fallEn & bMask))
			== $past(bFall & bState.fallEn & bMask)))
		else $error("port B falling edge lost");
	a_c_edge_sets: assert property (@(posedge core_clk) disable iff (rst) // [RULE7]
		(|(cFall & cState.fallEn & cMask))
		|=> ((cState.flags & $past(cFall & cState.fallEn & cMask))
			== $past(cFall & cState.fallEn & cMask)))
		else $error("port C falling edge lost");
	a_c_rise_sets: assert property (@(posedge core_clk) disable iff (rst) // [RULE7]
		(|(cRise & cState.riseEn & cMask))
		|=> ((cState.flags & $past(cRise & cState.riseEn & cMask))
			== $past(cRise & cState.riseEn & cMask)))
		else $error("port C rising edge lost");

	// Register writes, event status and variant masking
	a_b_rise_reg: assert property (@(posedge core_clk) disable iff (rst) // [RULE1]
		wrB0 |=> (bState.riseEn == $past(state_r.wData & bMask)))
		else $error("port B rise enable write wrong");
	a_c_fall_reg: assert property (@(posedge core_clk) disable iff (rst) // [RULE6]
		wrC1 |=> (cState.fallEn == $past(state_r.wData & cMask)))
		else $error("port C fall enable write wrong");
	a_b_low_dark: assert property (@(posedge core_clk) disable iff (rst) // [RULE4]
		((bState.flags | bState.riseEn | bState.fallEn) & ~B_IMPL_MASK) == 8'h00)
		else $error("port B low bit set");
	a_strap_fixed: assert property (@(posedge core_clk) disable iff (rst) // [RULE17]
		state_r.strapDone |=> $stable(state_r.strapSmall))
		else $error("variant strap changed after capture");
	a_small_b_dark: assert property (@(posedge core_clk) disable iff (rst) // [RULE17]
		state_r.strapSmall |-> (bState == '0))
		else $error("port B active on small variant");
	a_small_c_dark: assert property (@(posedge core_clk) disable iff (rst) // [RULE17]
		state_r.strapSmall |-> (((cState.flags | cState.riseEn | cState.fallEn) & ~SMALL_C_MASK) == 8'h00))
		else $error("port C upper pins active on small variant");
	a_mie_write: assert property (@(posedge core_clk) disable iff (rst)
		(wrGo && state_r.wLane0 && state_r.awAddr == OFF_CTRL)
		|=> (state_r.mie == $past(state_r.wData[CTRL_MIE_BIT])))
		else $error("master enable write lost");
	a_stat_b_set: assert property (@(posedge core_clk) disable iff (rst) // [RULE11]
		bSet |=> state_r.irqStat[IRQ_B_BIT])
		else $error("port B event status not set");
	a_stat_c_set: assert property (@(posedge core_clk) disable iff (rst) // [RULE11]
		cSet |=> state_r.irqStat[IRQ_C_BIT])
		else $error("port C event status not set");
	a_stat_w1c: assert property (@(posedge core_clk) disable iff (rst)
		(wrGo && state_r.wLane0 && state_r.awAddr == OFF_IRQ_STAT && !bSet && !cSet)
		|=> ((state_r.irqStat & $past(state_r.wData[1:0])) == 2'h0))
		else $error("event status not cleared by write one");

	// Bus answers
	a_read_one_cycle: assert property (@(posedge core_clk) disable iff (rst)
		(s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid)
		else $error("read data late");
	a_write_answers: assert property (@(posedge core_clk) disable iff (rst)
		wrGo |=> s_axi_bvalid)
		else $error("write response missing");
	a_wr_unmapped: assert property (@(posedge core_clk) disable iff (rst)
		(wrGo && !addrMapped(state_r.awAddr)) |=> (s_axi_bresp == RESP_SLVERR))
		else $error("unmapped write not refused");
	a_rd_unmapped: assert property (@(posedge core_clk) disable iff (rst)
		(s_axi_arvalid && s_axi_arready && !addrMapped(s_axi_araddr))
		|=> (s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h00000000))
		else $error("unmapped read not refused");

	c_b_flag: cover property (@(posedge core_clk) disable iff (rst) bSet);
	c_c_flag: cover property (@(posedge core_clk) disable iff (rst) cSet);
	c_wake: cover property (@(posedge core_clk) disable iff (rst) $rose(wakeReq));
	c_set_wins: cover property (@(posedge core_clk) disable iff (rst) wrC2 && cSet);
	c_irq_out: cover property (@(posedge core_clk) disable iff (rst) $rose(irqOut));
endmodule

// file: bench/pcd_pin_drv.sv
// Partner model: external logic driving the port B and port C pins
`timescale 1ns/1ps
module pcd_pin_drv #(
	parameter bit SLOW = 1'b0
) (
	// Clock
	input wire logic core_clk,
	// Levels the bench asks for
	input wire logic [7:0] wantB,
	input wire logic [7:0] wantC,
	// Pin levels
	output logic [7:0] port_b_pin = 8'h00,
	output logic [7:0] port_c_pin = 8'h00
);
	logic [7:0] lagB = 8'h00;
	logic [7:0] lagC = 8'h00;

	// Pins move just after an edge; slow mode lags one more cycle, like a sluggish source
	always @(posedge core_clk) begin
		lagB <= wantB;
		lagC <= wantC;
		port_b_pin <= SLOW ? lagB : wantB;
		port_c_pin <= SLOW ? lagC : wantC;
	end
endmodule

// file: bench/pin_change_detect_ports_b_c_tb.sv
// Testbench: pin change detect registers, edge flags, interrupts and small variant
`timescale 1ns/1ps
module pin_change_detect_ports_b_c_tb;
	import pcd_pkg::*;
	logic core_clk = 1'b0;
	logic rst = 1'b1;
	logic smallVariant = 1'b0;
	logic [7:0] port_b_pin, port_c_pin, wantB = 8'h00, wantC = 8'h00;
	logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
	logic [31:0] s_axi_wdata = 32'h00000000, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rsp;
	logic changeIrq, wakeReq, irqOut;
	logic [31:0] rd;
	logic [7:0] ri, fa, ps, pe, eb, ec;
	int fails = 0;
	int n_compared = 0;
	// Rows: rise enable, fall enable, start pins, end pins, port B flags, port C flags
	logic [47:0] rows [6] = '{48'hFF_00_00_FF_F0_FF, 48'h00_FF_00_FF_00_00,
		48'h00_FF_FF_00_F0_FF, 48'hA5_5A_0F_F0_A0_AA, 48'h00_00_00_FF_00_00,
		48'hFF_FF_3C_C3_F0_FF};
	logic [11:0] offs [6] = '{OFF_B_RISE, OFF_B_FALL, OFF_B_FLAG, OFF_C_RISE, OFF_C_FALL,
		OFF_C_FLAG};

	pcd_top dut (.core_clk, .rst, .smallVariant, .port_b_pin, .port_c_pin, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .changeIrq, .wakeReq, .irqOut);
	pcd_pin_drv #(.SLOW(1'b1)) drv (.core_clk, .wantB, .wantC, .port_b_pin, .port_c_pin);

	// 250 MHz clock
	always #2 core_clk = ~core_clk;

	// ------------------------------------------------------------
	// Bus and check tasks
	// ------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected %s: expected %h, seen %h", nm, exp, seen);
		end
	endtask

	// Handshakes are sampled at the rising edge, before the design's registers move
	task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s = 4'hF);
		logic aw, w, b;
		b = 1'b0;
		@(posedge core_clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= {24'h000000, d};
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		while (!b) begin
			@(posedge core_clk);
			aw = s_axi_awvalid & s_axi_awready;
			w = s_axi_wvalid & s_axi_wready;
			b = s_axi_bvalid & s_axi_bready;
			rsp = s_axi_bresp;
			if (aw) s_axi_awvalid <= 1'b0;
			if (w) s_axi_wvalid <= 1'b0;
			if (b) s_axi_bready <= 1'b0;
		end
	endtask

	task automatic rc(input logic [11:0] a, input logic [7:0] e);
		logic ar, r;
		r = 1'b0;
		@(posedge core_clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		while (!r) begin
			@(posedge core_clk);
			ar = s_axi_arvalid & s_axi_arready;
			r = s_axi_rvalid & s_axi_rready;
			rd = s_axi_rdata;
			rsp = s_axi_rresp;
			if (ar) s_axi_arvalid <= 1'b0;
			if (r) s_axi_rready <= 1'b0;
		end
		chk($sformatf("reg %h", a), rd, {24'h000000, e});
	endtask

	// Settle time covers the slow pin source, three sync flops and the flag register
	task automatic pins(input logic [7:0] b, input logic [7:0] c);
		@(posedge core_clk);
		wantB <= b;
		wantC <= c;
		repeat (8) @(posedge core_clk);
	endtask

	task automatic end_sim();
		if (fails == 0 && n_compared > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// ------------------------------------------------------------
	// Stimulus
	// ------------------------------------------------------------
	// Watchdog: the whole sequence needs a few thousand cycles at most
	initial begin
		repeat (20000) @(posedge core_clk);
		fails++;
		end_sim();
	end

	// Reset, table of edge cases, then hand-written cases
	initial begin
		repeat (6) @(posedge core_clk);
		rst <= 1'b0;
		foreach (offs[i]) rc(offs[i], 8'h00);
		foreach (rows[i]) begin
			{ri, fa, ps, pe, eb, ec} = rows[i];
			wr(OFF_B_RISE, ri);
			wr(OFF_B_FALL, fa);
			wr(OFF_C_RISE, ri);
			wr(OFF_C_FALL, fa);
			rc(OFF_B_RISE, ri & B_IMPL_MASK);
			rc(OFF_C_FALL, fa);
			pins(ps, ps);
			wr(OFF_B_FLAG, 8'h00);
			wr(OFF_C_FLAG, 8'h00);
			pins(pe, pe);
			rc(OFF_B_FLAG, eb);
			rc(OFF_C_FLAG, ec);
			rc(OFF_CTRL, {6'h00, |{eb, ec}, 1'b0});
		end
		@(negedge core_clk);
		chk("irq masked", 32'(changeIrq), 32'h0);
		wr(OFF_CTRL, 8'h01);
		@(negedge core_clk);
		chk("irq wake", 32'({changeIrq, wakeReq}), 32'h3);
		repeat (20) @(posedge core_clk);
		rc(OFF_C_FLAG, 8'hFF);
		wr(OFF_B_FLAG, 8'h0F);
		rc(OFF_B_FLAG, 8'h00);
		wr(OFF_C_FLAG, 8'h00);
		@(negedge core_clk);
		chk("irq clear", 32'(changeIrq), 32'h0);
		// Event status with mask and write-one-to-clear
		wr(OFF_IRQ_MASK, 8'h00);
		@(negedge core_clk);
		chk("irq out masked", 32'(irqOut), 32'h0);
		wr(OFF_IRQ_MASK, 8'h03);
		@(negedge core_clk);
		chk("irq out", 32'(irqOut), 32'h1);
		wr(OFF_IRQ_STAT, 8'h03);
		rc(OFF_IRQ_STAT, 8'h00);
		chk("irq out cleared", 32'(irqOut), 32'h0);
		// Strobe-less write ignored but answered OKAY, and an unmapped place
		wr(OFF_C_FALL, 8'h00);
		wr(OFF_C_FALL, 8'hFF, 4'h0);
		chk("no strobe resp", 32'(rsp), 32'(RESP_OKAY));
		rc(OFF_C_FALL, 8'h00);
		wr(12'h100, 8'hFF);
		chk("unmapped wr resp", 32'(rsp), 32'(RESP_SLVERR));
		rc(12'h100, 8'h00);
		chk("unmapped rd resp", 32'(rsp), 32'(RESP_SLVERR));
		// Second reset into the small variant
		@(posedge core_clk);
		smallVariant <= 1'b1;
		rst <= 1'b1;
		repeat (2) @(posedge core_clk);
		rst <= 1'b0;
		rc(OFF_CTRL, 8'h00);
		wr(OFF_B_RISE, 8'hFF);
		wr(OFF_C_RISE, 8'hFF);
		rc(OFF_B_RISE, 8'h00);
		rc(OFF_C_RISE, 8'h3F);
		pins(8'h00, 8'h00);
		pins(8'hFF, 8'hFF);
		rc(OFF_B_FLAG, 8'h00);
		rc(OFF_C_FLAG, 8'h3F);
		end_sim();
	end
endmodule
